// ### hw/seq_core.sv
// Purpose: Program counter sequencing, paging, skip timing and build options
// Assumes: Classic Wishbone slave, one clock, options fixed at elaboration
// Notes: Software steps the sequencer by writing an operation to the step register
//
// Overview of operation
// - Skipped instruction costs one cycle per byte
// - ROM is sixteen pages of sixty-four words
// - Ten-bit counter crosses page boundaries freely
// - Last-word jumps act as in next page
// - Indirect source at pages 2,7,11,15 and jump at pages 3,7,11,15 reach next group
// - Clock-output pin takes one of five roles
// - Clock-input option picks instruction clock divider
// - Segment bits offer four driver types
// - Serial out and clock offer three drivers
// - I/O and strobe bits: standard or open-drain
// - Sense and serial inputs: load or high-impedance
// - Reset pin: load or high-impedance
// - Function and bonding option selection
// - Serial out high selects test mode by serial-in
`timescale 1ns/10ps
`default_nettype none
module seq_core #(
    parameter logic [2:0] OPT_CKO = 3'h0, // Clock-output pin role
    parameter logic [2:0] OPT_CKI = 3'h0, // Clock-input divider choice
    parameter logic [0:0] OPT_RST_HIZ = 1'h0, // Reset pin loading
    parameter logic [15:0] OPT_SEG_DRV = 16'h0000, // Two bits per segment bit
    parameter logic [1:0] OPT_SO_DRV = 2'h0, // Serial-out driver
    parameter logic [1:0] OPT_SK_DRV = 2'h0, // Serial-clock driver
    parameter logic [3:0] OPT_IO_OD = 4'h0, // Four-bit port open-drain
    parameter logic [3:0] OPT_STB_OD = 4'h0, // Strobe open-drain
    parameter logic [3:0] OPT_SENSE_HIZ = 4'h0, // Sense pad loading
    parameter logic [0:0] OPT_SI_HIZ = 1'h0, // Serial-in loading
    parameter logic [0:0] OPT_HOSTBUS = 1'h0, // Host-bus peripheral mode
    parameter logic [0:0] OPT_BOND24 = 1'h0 // Narrow bonding variant
) (
    input wire logic clk, // System clock
    input wire logic reset, // Asynchronous reset, active high
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    input wire logic wb_we_i, // Wishbone write enable
    input wire logic [3:0] wb_adr_i, // Wishbone byte address
    input wire logic [3:0] wb_sel_i, // Wishbone byte selects
    input wire logic [31:0] wb_dat_i, // Wishbone write data
    output logic [31:0] wb_dat_o, // Wishbone read data
    output logic wb_ack_o, // Wishbone acknowledge
    input wire logic ser_in, // Serial-in pin level
    input wire logic ser_out_in, // Serial-out pin level seen externally
    output logic [9:0] pc_o, // Program counter
    output logic instr_tick_o, // Instruction clock enable pulse
    output logic test_ram_o, // RAM and logic test mode
    output logic test_rom_o, // ROM test mode
    output logic [2:0] cko_role_o, // Clock-output pin role
    output logic [4:0] pull_en_o, // Load devices: sense pads 3..0 and reset at bit 4
    output logic si_pull_o, // Serial-in load device enabled
    output logic hostbus_o, // Host-bus mode active
    output seq_pkg::pins_t pins_o // Pad outputs and enables
);
    // Register and next-value state
    logic [9:0] pc_r, pc_nxt;
    logic [3:0] page_eff;
    logic [4:0] div_r;
    logic tick_r;
    logic [7:0] ctrl_r;
    logic [9:0] tgt_r;
    logic [1:0] skip_r;
    logic busy_r;
    logic [7:0] seg_d;
    logic [3:0] io_d, stb_d;
    logic [7:0] step_data;
    logic step_go;

    // Option-derived constants; fixed at build time
    localparam logic [4:0] DIV_N = (OPT_CKI == seq_pkg::CKI_XTAL8 ||
        OPT_CKI == seq_pkg::CKI_TTL8) ? seq_pkg::DIV8 :
        (OPT_CKI == seq_pkg::CKI_RC) ? seq_pkg::DIV_RC : seq_pkg::DIV16;
    // Narrow bonding removes sense pads 0..3 and host-bus option
    localparam logic [3:0] SENSE_EFF = OPT_BOND24 ? 4'hF : OPT_SENSE_HIZ;
    localparam logic HOST_EFF = OPT_BOND24 ? 1'b0 : OPT_HOSTBUS;

    // Page of the address an instruction at pc behaves as though it resides in
    function automatic logic [3:0] eff_page(input logic [9:0] pc);
        eff_page = (pc[5:0] == seq_pkg::LAST_WORD) ? pc[9:6] + 4'h1 : pc[9:6];
    endfunction

    // Indirect source page group; last word of 2,7,11,15 moves to next group
    function automatic logic [1:0] ind_group(input logic [9:0] pc);
        ind_group = pc[9:8];
        if (pc[5:0] == seq_pkg::LAST_WORD && (pc[9:6] == 4'h2 || pc[9:6] == 4'h7 ||
            pc[9:6] == 4'hB || pc[9:6] == 4'hF))
            ind_group = pc[9:8] + 2'h1;
    endfunction

    // Instruction clock divider from selected source
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            div_r <= 5'h00;
            tick_r <= 1'b0;
        end else if (div_r == DIV_N - 5'h01) begin
            div_r <= 5'h00;
            tick_r <= 1'b1;
        end else begin
            div_r <= div_r + 5'h01;
            tick_r <= 1'b0;
        end
    end

    // Step register decode: op in [2:0], skip bytes in [4:3], data in [15:8]
    assign step_go = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o &
        (wb_adr_i == seq_pkg::REG_STEP) & wb_sel_i[0] & ~busy_r & (skip_r == 2'h0);
    assign step_data = wb_dat_i[15:8];

    // Next program counter for the requested operation
    always_comb begin
        page_eff = eff_page(pc_r);
        pc_nxt = pc_r + 10'h001;
        unique case (wb_dat_i[2:0])
            3'(seq_pkg::OP_NEAR_JUMP): begin
                if (page_eff[3:1] == 3'h1)
                    pc_nxt = {3'h1, step_data[6:0]}; // Within page 2/3 pair
                else
                    pc_nxt = {page_eff, step_data[5:0]};
            end
            3'(seq_pkg::OP_SUB_CALL): pc_nxt = {seq_pkg::SUB_PAGE, step_data[5:0]};
            3'(seq_pkg::OP_IND_JUMP): pc_nxt = {page_eff[3:2], step_data};
            3'(seq_pkg::OP_TABLE_FETCH): pc_nxt = pc_r + 10'h001;
            default: pc_nxt = pc_r + 10'h001;
        endcase
    end

    // Program counter, skip accounting and two-cycle indirect hold
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pc_r <= seq_pkg::PC_RESET;
            skip_r <= 2'h0;
            busy_r <= 1'b0;
            tgt_r <= 10'h000;
        end else if (tick_r && skip_r != 2'h0) begin
            pc_r <= pc_r + 10'h001;
            skip_r <= skip_r - 2'h1;
        end else if (tick_r && busy_r) begin
            busy_r <= 1'b0;
        end else if (step_go) begin
            pc_r <= pc_nxt;
            skip_r <= wb_dat_i[4:3];
            busy_r <= (wb_dat_i[2:0] == 3'(seq_pkg::OP_IND_JUMP)) ||
                (wb_dat_i[2:0] == 3'(seq_pkg::OP_TABLE_FETCH));
            tgt_r <= {ind_group(pc_r), step_data};
        end
    end

    // Control register: pad data for segment, I/O and strobe bits
    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            ctrl_r <= 8'h00;
        else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o &&
                 wb_adr_i == seq_pkg::REG_CTRL && wb_sel_i[0])
            ctrl_r <= wb_dat_i[7:0];
    end
    assign seg_d = ctrl_r;
    assign io_d = ctrl_r[3:0];
    assign stb_d = ctrl_r[7:4];

    // Bus answer: one wait, ack for one cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            unique case (wb_adr_i)
                seq_pkg::REG_CTRL: wb_dat_o <= {24'h00_0000, ctrl_r};
                seq_pkg::REG_STEP: wb_dat_o <= {22'h00_0000, pc_r};
                seq_pkg::REG_STAT: wb_dat_o <= {26'h000_0000, test_rom_o, test_ram_o,
                    busy_r, skip_r, tick_r};
                seq_pkg::REG_TGT: wb_dat_o <= {22'h00_0000, tgt_r};
                default: wb_dat_o <= seq_pkg::UNMAPPED;
            endcase
        end
    end

    // Test modes, pin roles and loading options
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            test_ram_o <= 1'b0;
            test_rom_o <= 1'b0;
            pc_o <= 10'h000;
            instr_tick_o <= 1'b0;
            cko_role_o <= 3'h0;
            pull_en_o <= 5'h00;
            si_pull_o <= 1'b0;
            hostbus_o <= 1'b0;
        end else begin
            test_ram_o <= ser_out_in & ser_in;
            test_rom_o <= ser_out_in & ~ser_in;
            pc_o <= pc_r;
            instr_tick_o <= tick_r;
            cko_role_o <= OPT_CKO;
            pull_en_o <= {~OPT_RST_HIZ, ~SENSE_EFF};
            si_pull_o <= ~OPT_SI_HIZ;
            hostbus_o <= HOST_EFF;
        end
    end

    // Segment bit drivers with four options; I/O and strobe drivers with two
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_seg
            pin_drive u_seg (
                .clk(clk), .reset(reset), .drv(OPT_SEG_DRV[2*gi +: 2]),
                .d(seg_d[gi]), .en(1'b1),
                .q(pins_o.seg_out[gi]), .oe_n(pins_o.seg_oe_n[gi])
            );
        end
        for (gi = 0; gi < 4; gi++) begin : g_io
            pin_drive u_io (
                .clk(clk), .reset(reset), .drv({1'b0, OPT_IO_OD[gi]}),
                .d(io_d[gi]), .en(1'b1),
                .q(pins_o.io_out[gi]), .oe_n(pins_o.io_oe_n[gi])
            );
            pin_drive u_stb (
                .clk(clk), .reset(reset), .drv({1'b0, OPT_STB_OD[gi]}),
                .d(stb_d[gi]), .en(1'b1),
                .q(pins_o.strobe_out[gi]), .oe_n(pins_o.strobe_oe_n[gi])
            );
        end
    endgenerate

    // Serial pins: push-pull maps to a driven two-level output
    pin_drive u_so (
        .clk(clk), .reset(reset),
        .drv(OPT_SO_DRV == seq_pkg::DRV_PP ? seq_pkg::DRV_STD : OPT_SO_DRV),
        .d(ctrl_r[0]), .en(1'b1),
        .q(pins_o.ser_out), .oe_n(pins_o.ser_out_oe_n)
    );
    pin_drive u_sk (
        .clk(clk), .reset(reset),
        .drv(OPT_SK_DRV == seq_pkg::DRV_PP ? seq_pkg::DRV_STD : OPT_SK_DRV),
        .d(tick_r), .en(1'b1),
        .q(pins_o.ser_clk), .oe_n(pins_o.ser_clk_oe_n)
    );
endmodule
`default_nettype wire

// ### common/seq_pkg.sv
// Purpose: Shared constants and types for the sequencer and option block
// Assumes: 100 MHz system clock, option values fixed at elaboration
// Notes: Register offsets are byte addresses on a 32-bit classic Wishbone slave
package seq_pkg;
    localparam int PC_W = 10;
    localparam int PAGE_W = 4;
    localparam int WORD_W = 6;
    localparam int PAGES = 16;
    localparam int PAGE_WORDS = 64;
    localparam logic [5:0] LAST_WORD = 6'h3F;
    localparam logic [9:0] PC_RESET = 10'h000;
    localparam logic [3:0] SUB_PAGE = 4'h2;
    // Clock-input option codes
    localparam logic [2:0] CKI_XTAL16 = 3'h0;
    localparam logic [2:0] CKI_XTAL8 = 3'h1;
    localparam logic [2:0] CKI_TTL16 = 3'h2;
    localparam logic [2:0] CKI_TTL8 = 3'h3;
    localparam logic [2:0] CKI_RC = 3'h4;
    localparam logic [4:0] DIV16 = 5'h10;
    localparam logic [4:0] DIV8 = 5'h08;
    localparam logic [4:0] DIV_RC = 5'h04;
    // Clock-output pin roles
    localparam logic [2:0] CKO_XTAL = 3'h0;
    localparam logic [2:0] CKO_KEEPALIVE = 3'h1;
    localparam logic [2:0] CKO_IN_LOAD = 3'h2;
    localparam logic [2:0] CKO_SYNC = 3'h3;
    localparam logic [2:0] CKO_IN_HIZ = 3'h4;
    // Driver codes
    localparam logic [1:0] DRV_STD = 2'h0;
    localparam logic [1:0] DRV_OD = 2'h1;
    localparam logic [1:0] DRV_LED = 2'h2;
    localparam logic [1:0] DRV_TRI = 2'h3;
    localparam logic [1:0] DRV_PP = 2'h2;
    // Register byte offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STEP = 4'h4;
    localparam logic [3:0] REG_STAT = 4'h8;
    localparam logic [3:0] REG_TGT = 4'hC;
    localparam logic [31:0] UNMAPPED = 32'h0000_0000;

    typedef enum logic [2:0] {
        OP_SEQ, OP_NEAR_JUMP, OP_SUB_CALL, OP_IND_JUMP, OP_TABLE_FETCH
    } op_t;

    typedef struct packed {
        logic [7:0] seg_out;
        logic [7:0] seg_oe_n;
        logic [3:0] io_out;
        logic [3:0] io_oe_n;
        logic [3:0] strobe_out;
        logic [3:0] strobe_oe_n;
        logic ser_out;
        logic ser_out_oe_n;
        logic ser_clk;
        logic ser_clk_oe_n;
    } pins_t;
endpackage

// ### hw/pin_drive.sv
// Purpose: Turns a driver option and data bit into pin output and enable
// Assumes: Output enable is active low; low means the pin is driven
// Notes: Open drain drives only a low level; standard and LED drive both levels
`timescale 1ns/10ps
`default_nettype none
module pin_drive (
    input wire logic clk, // System clock
    input wire logic reset, // Asynchronous reset, active high
    input wire logic [1:0] drv, // Driver option code
    input wire logic d, // Data to drive
    input wire logic en, // Three-state enable for the three-state driver mode
    output logic q, // Registered pin level
    output logic oe_n // Registered output enable, low drives
);
    // Register pin per driver option
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            q <= 1'b0;
            oe_n <= 1'b1;
        end else begin
            unique case (drv)
                seq_pkg::DRV_STD, seq_pkg::DRV_LED: begin
                    q <= d;
                    oe_n <= 1'b0;
                end
                seq_pkg::DRV_OD: begin
                    q <= 1'b0;
                    oe_n <= d;
                end
                seq_pkg::DRV_TRI: begin
                    q <= d;
                    oe_n <= ~en;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ### tb/seq_core_properties.sv
// Purpose: Port checks for the sequencer
// Assumes: Divide-by-16 instruction clock
// Notes: Bound into seq_core
`timescale 1ns/10ps
`default_nettype none
module seq_core_checker #(
    parameter logic [2:0] OPT_CKO = 3'h0, // Role
    parameter logic [0:0] OPT_RST_HIZ = 1'h0, // Reset load
    parameter logic [3:0] OPT_SENSE_HIZ = 4'h0, // Sense load
    parameter logic [0:0] OPT_SI_HIZ = 1'h0, // Serial-in load
    parameter logic [0:0] OPT_HOSTBUS = 1'h0, // Host bus
    parameter logic [0:0] OPT_BOND24 = 1'h0 // Bonding
) (
    input wire logic clk, // Clock
    input wire logic reset, // Reset
    input wire logic wb_cyc_i, // Cycle
    input wire logic wb_stb_i, // Strobe
    input wire logic wb_ack_o, // Ack
    input wire logic ser_in, // Serial in
    input wire logic ser_out_in, // Serial out level
    input wire logic instr_tick_o, // Tick
    input wire logic test_ram_o, // RAM test
    input wire logic test_rom_o, // ROM test
    input wire logic [2:0] cko_role_o, // Role
    input wire logic [4:0] pull_en_o, // Loads
    input wire logic si_pull_o, // Serial-in load
    input wire logic hostbus_o // Host bus
);
    // One clock domain, all checks quiet in reset
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
    a_ram_test_entry: assert property (ser_out_in && ser_in |=> test_ram_o && !test_rom_o)
        else $error("ram test");
    a_rom_test_entry: assert property (ser_out_in && !ser_in |=> test_rom_o && !test_ram_o)
        else $error("rom test");
    a_no_test_mode: assert property (!ser_out_in |=> !test_ram_o && !test_rom_o)
        else $error("test mode");
    a_tick_quiet: assert property (instr_tick_o |=> !instr_tick_o [*8]) else $error("tick");
    a_tick_period: assert property (instr_tick_o |-> ##16 instr_tick_o) else $error("period");
    a_role_fixed: assert property (!$past(reset) |-> cko_role_o == OPT_CKO)
        else $error("role");
    a_loads_fixed: assert property (!$past(reset) |-> pull_en_o ==
        {~OPT_RST_HIZ, OPT_BOND24 ? 4'h0 : ~OPT_SENSE_HIZ} && si_pull_o == ~OPT_SI_HIZ)
        else $error("loads");
    a_hostbus_fixed: assert property (!$past(reset) |-> hostbus_o ==
        (OPT_HOSTBUS && !OPT_BOND24)) else $error("host bus");
    // Main scenarios reached
    cover property (test_ram_o);
    cover property (test_rom_o);
    cover property (wb_ack_o);
endmodule
bind seq_core seq_core_checker #(.OPT_CKO(OPT_CKO), .OPT_RST_HIZ(OPT_RST_HIZ),
    .OPT_SENSE_HIZ(OPT_SENSE_HIZ), .OPT_SI_HIZ(OPT_SI_HIZ), .OPT_HOSTBUS(OPT_HOSTBUS),
    .OPT_BOND24(OPT_BOND24)) chk (.clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .ser_in(ser_in), .ser_out_in(ser_out_in),
    .instr_tick_o(instr_tick_o), .test_ram_o(test_ram_o), .test_rom_o(test_rom_o),
    .cko_role_o(cko_role_o), .pull_en_o(pull_en_o), .si_pull_o(si_pull_o),
    .hostbus_o(hostbus_o));
`default_nettype wire

// ### tb/tb_mcu_sequencer_and_mask_options.sv
// Purpose: Self-checking bench for the sequencer
// Assumes: Wishbone step register drives the sequencer
// Notes: Options chosen to mix driver types
`timescale 1ns/10ps
`default_nettype none
module tb_mcu_sequencer_and_mask_options;
    localparam logic [7:0] SEG_OD = 8'h01; // Open-drain segment bits
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic si = 1'b0;
    logic so = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [3:0] sel = 4'h3;
    logic tick;
    logic [31:0] dat = 32'h0;
    logic [31:0] rd, wb_dat_o;
    logic wb_ack_o, test_ram, test_rom, si_pull, hostbus;
    logic [9:0] pc_o;
    logic [2:0] cko_role;
    logic [4:0] pull_en;
    seq_pkg::pins_t pins;
    int n_mismatch = 0;
    int tests_run = 0;
    // Wide bonding kept, so the narrow-variant option limits do not apply
    seq_core #(.OPT_CKO(seq_pkg::CKO_SYNC), .OPT_RST_HIZ(1'h1), .OPT_SEG_DRV(16'h0039),
        .OPT_SO_DRV(seq_pkg::DRV_OD), .OPT_IO_OD(4'h5), .OPT_STB_OD(4'h3),
        .OPT_SENSE_HIZ(4'h6), .OPT_SI_HIZ(1'h1)) uut (.clk(clk), .reset(reset),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ser_in(si),
        .ser_out_in(so), .pc_o(pc_o), .instr_tick_o(tick), .test_ram_o(test_ram),
        .test_rom_o(test_rom), .cko_role_o(cko_role), .pull_en_o(pull_en),
        .si_pull_o(si_pull), .hostbus_o(hostbus), .pins_o(pins));
    // Clock at 100 MHz
    initial forever #5 clk = ~clk;
    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // One classic cycle, held until ack is sampled
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (wb_ack_o !== 1'b1 && i < 20);
        rd = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (i >= 20) begin
            n_mismatch++;
            test_done();
        end
    endtask
    // Poll status until not busy and no skip pending
    task idle;
        int k;
        k = 0;
        do begin
            bus(1'b0, seq_pkg::REG_STAT, 32'h0);
            k++;
        end while (rd[3:1] !== 3'h0 && k < 40);
        if (k >= 40) begin
            n_mismatch++;
            test_done();
        end
    endtask
    task step(input logic [31:0] d);
        idle();
        bus(1'b1, seq_pkg::REG_STEP, d);
    endtask
    task pc_is(input logic [9:0] e);
        idle();
        bus(1'b0, seq_pkg::REG_STEP, 32'h0);
        check("pc", {22'h0, e}, rd);
        check("pc_o", {22'h0, e}, {22'h0, pc_o});
    endtask
    task t_options;
        int n;
        n = 0;
        check("pc start", 32'h0, {22'h0, pc_o});
        repeat (32) begin
            @(posedge clk);
            n += tick;
        end
        check("ticks", 32'h2, n);
        check("role", 32'h3, {29'h0, cko_role});
        check("loads", 32'h9, {27'h0, pull_en});
        check("si load", 32'h0, {31'h0, si_pull});
        check("host bus", 32'h0, {31'h0, hostbus});
    endtask
    task t_paging;
        step(32'h3F01);
        pc_is(10'h03F);
        step(32'h0000);
        pc_is(10'h040);
        step(32'h3F01);
        step(32'h0501);
        pc_is(10'h085);
    endtask
    task t_indirect;
        step(32'hFF03);
        step(32'hFF03);
        pc_is(10'h1FF);
        step(32'h1003);
        pc_is(10'h210);
        bus(1'b0, seq_pkg::REG_TGT, 32'h0);
        check("source", 32'h210, rd);
        step(32'h0504);
        pc_is(10'h211);
        step(32'h0502);
        pc_is(10'h085);
    endtask
    // Step refused while two skipped bytes are pending
    task t_skip;
        step(32'h0010);
        bus(1'b1, seq_pkg::REG_STEP, 32'h0001);
        pc_is(10'h088);
    endtask
    task t_pins;
        logic [7:0] d;
        for (int j = 0; j < 2; j++) begin
            d = j ? 8'h5A : 8'hA5;
            bus(1'b1, seq_pkg::REG_CTRL, {24'h0, d});
            repeat (2) @(posedge clk);
            check("seg", {16'h0, d & ~SEG_OD, d & SEG_OD}, {16'h0, pins.seg_out, pins.seg_oe_n});
            check("io", {24'h0, d[3:0] & 4'hA, d[3:0] & 4'h5}, {24'h0, pins.io_out, pins.io_oe_n});
            check("strobe", {24'h0, d[7:4] & 4'hC, d[7:4] & 4'h3},
                {24'h0, pins.strobe_out, pins.strobe_oe_n});
            check("ser out", {31'h0, d[0]}, {30'h0, pins.ser_out, pins.ser_out_oe_n});
        end
        bus(1'b1, 4'h2, 32'hFF);
        bus(1'b0, 4'h2, 32'h0);
        check("unmapped", 32'h0, rd);
        bus(1'b0, seq_pkg::REG_CTRL, 32'h0);
        check("ctrl", 32'h5A, rd);
        // Write without lane 0 selected must leave the pad data alone
        sel <= 4'h0;
        bus(1'b1, seq_pkg::REG_CTRL, 32'h0);
        sel <= 4'h3;
        bus(1'b0, seq_pkg::REG_CTRL, 32'h0);
        check("ctrl sel", 32'h5A, rd);
    endtask
    task t_test;
        for (int j = 0; j < 4; j++) begin
            @(posedge clk);
            so <= j[1];
            si <= j[0];
            repeat (3) @(posedge clk);
            check("ram test", {31'h0, j == 3}, {31'h0, test_ram});
            check("rom test", {31'h0, j == 2}, {31'h0, test_rom});
        end
        so <= 1'b0;
    endtask
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        t_options();
        t_paging();
        t_indirect();
        t_skip();
        t_pins();
        t_test();
        test_done();
    end
endmodule
`default_nettype wire
